// ---- rtl/sfp_array.sv ----
`timescale 1ns/10ps
`default_nettype none

module sfp_array #(
  parameter int unsigned ADDR_W = 15,
  parameter int unsigned DATA_W = 8
) (
  // clock
  input  wire logic              ref_clk,
  // write port
  input  wire logic              set_write_latch_cmd,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  // registered read port
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);

  typedef struct packed {
    logic [DATA_W-1:0] rd;
  } sfp_array_t;

  sfp_array_t st;
  sfp_array_t next_st;
  logic [DATA_W-1:0] cells [2**ADDR_W];

  if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin : gSizeCheck
    $error("sfp_array: ADDR_W must be 1..16 and DATA_W at least 1");
  end

  always_comb begin
    next_st = st;
    next_st.rd = cells[rdAddr];
  end

  // array contents model retained storage, so no reset here
  always_ff @(posedge ref_clk) begin
    st <= next_st;
    if (set_write_latch_cmd) begin
      cells[wrAddr] <= wrData;
    end
  end

  assign rdData = st.rd;

endmodule

`default_nettype wire

// ---- rtl/sfp_pkg.sv ----
`default_nettype none

package sfp_pkg;

  // array geometry
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam logic [14:0] ADDR_MAX = 15'h7FFF;
  localparam logic [14:0] ADDR_ZERO = 15'h0000;

  // block protection boundaries
  localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
  localparam logic [14:0] PROT_HALF_BASE = 15'h4000;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;

  // status register layout and value after reset
  localparam int unsigned SR_PIN_EN_BIT = 7;
  localparam int unsigned SR_BP_HI_BIT = 3;
  localparam int unsigned SR_BP_LO_BIT = 2;
  localparam int unsigned SR_WEL_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_MEM = 8'h03;
  localparam logic [7:0] OP_WRITE_MEM = 8'h02;

  // synchroniser lanes and their idle levels
  localparam int unsigned PIN_CNT = 5;
  localparam int unsigned PIN_SI = 0;
  localparam int unsigned PIN_SCK = 1;
  localparam int unsigned PIN_CS = 2;
  localparam int unsigned PIN_WP = 3;
  localparam int unsigned PIN_HOLD = 4;
  localparam logic [4:0] SYNC_RESET = 5'h1C;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_ADDR,
    PH_WRDATA,
    PH_RDDATA,
    PH_RDSTAT,
    PH_WRSTAT,
    PH_DONE_IGN
  } sfp_phase_t;

endpackage

`default_nettype wire

// ---- rtl/sfp_protect_access.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - status: bit7 pin enable, bits3:2 block protect, bit1 latch; others read zero
// - status write drops the latch bit of its data; set, clear, status write and memory write commands change the latch
// - latch reads 1 when writes enabled, 0 otherwise; cleared after reset
// - pin enable and block protect bits are not retained; reset loads them with zero
// - block protect 00 none, 01 6000h up, 10 4000h up, 11 everything
// - array writes blocked only by clear latch or protected address
// - pin enable set and protect pin low rejects status writes
// - protect pin never affects array writes
// - status write needs latch set and counts as a write
// - status read shifts out the current status byte
// - two address bytes follow memory opcodes; top address bit ignored
// - address increments per data byte and wraps 7FFFh to 0000h
// - each data byte written right after its eighth bit; no busy
// - burst reaching protected address stops increment and drops further bytes
// - write ends at select rise; input bytes taken msb first
// - read data driven msb first; serial input ignored during data
// - read ends at select rise and output goes high impedance
// - hold low while clock low pauses; hold high while clock low resumes
// - opcodes 06h set, 04h clear, 05h status read, 01h status write, 03h/02h memory
// - latch cleared at select rise ending clear, status write or memory write
// - unknown opcode ignores input until next select and keeps output off
// - clock level at select fall picks mode 0 or 3; rise samples, fall shifts

module sfp_protect_access
  import sfp_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // serial interface pins
  input  wire logic chipSel_b,
  input  wire logic sckPin,
  input  wire logic siPin,
  output logic      serOut,
  output logic      serOutOe_b,
  // protection and hold pins
  input  wire logic writeProt_b,
  input  wire logic holdPin_b
);
  import sfp_pkg::*;

  typedef struct packed {
    sfp_phase_t        phase;
    logic [2:0]        bitCnt;
    logic [6:0]        shiftIn;
    logic [7:0]        shiftOut;
    logic [ADDR_W-1:0] addr;
    logic              addrLow;
    logic              isWrite;
    logic              write_latch_flag;
    logic              pinEn;
    logic [1:0]        bp;
    logic              clrPend;
    logic              halted;
    logic              hold;
    logic              drive;
    logic              mode3;
    logic              sckPrev;
    logic              serOut;
    logic              serOutOe_b;
    logic              memWe;
    logic [ADDR_W-1:0] memAddr;
    logic [DATA_W-1:0] memData;
  } sfp_state_t;

  localparam sfp_state_t ST_RESET = '{
    phase:      PH_IDLE,
    write_latch_flag:        STATUS_RESET[SR_WEL_BIT],
    pinEn:      STATUS_RESET[SR_PIN_EN_BIT],
    bp:         {STATUS_RESET[SR_BP_HI_BIT], STATUS_RESET[SR_BP_LO_BIT]},
    serOutOe_b: 1'b1,
    default:    '0
  };

  sfp_state_t        st;
  sfp_state_t        next_st;
  logic [PIN_CNT-1:0] pinSync;
  logic              csS;
  logic              sckS;
  logic              siS;
  logic              wpS;
  logic              holdS;
  logic              rise;
  logic              fall;
  logic [7:0]        inByte;
  logic [7:0]        statByte;
  logic [DATA_W-1:0] rdData;
  logic              opDone;
  logic              expBit;

  function automatic logic isProt(input logic [ADDR_W-1:0] a, input logic [1:0] b);
    logic p;
    p = 1'b0;
    unique case (b)
      BP_NONE:    p = 1'b0;
      BP_QUARTER: p = (a >= PROT_QUARTER_BASE);
      BP_HALF:    p = (a >= PROT_HALF_BASE);
      BP_ALL:     p = 1'b1;
    endcase
    return p;
  endfunction

  sfp_sync #(
    .WIDTH     (PIN_CNT),
    .RESET_VAL (SYNC_RESET)
  ) uSync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .din     ({holdPin_b, writeProt_b, chipSel_b, sckPin, siPin}),
    .dout    (pinSync)
  );

  sfp_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) uArray (
    .ref_clk (ref_clk),
    .set_write_latch_cmd    (st.memWe),
    .wrAddr  (st.memAddr),
    .wrData  (st.memData),
    .rdAddr  (st.addr),
    .rdData  (rdData)
  );

  assign csS = pinSync[PIN_CS];
  assign sckS = pinSync[PIN_SCK];
  assign siS = pinSync[PIN_SI];
  assign wpS = pinSync[PIN_WP];
  assign holdS = pinSync[PIN_HOLD];
  // both modes sample on rise and shift on fall
  assign rise = sckS && !st.sckPrev;
  assign fall = !sckS && st.sckPrev;
  // msb first assembly
  assign inByte = {st.shiftIn, siS};
  assign opDone = rise && !st.hold && !csS && st.phase == PH_OPCODE && st.bitCnt == 3'h7;

  // unused bits read zero
  always_comb begin
    statByte = 8'h00;
    statByte[SR_PIN_EN_BIT] = st.pinEn;
    statByte[SR_BP_HI_BIT] = st.bp[1];
    statByte[SR_BP_LO_BIT] = st.bp[0];
    statByte[SR_WEL_BIT] = st.write_latch_flag;
  end
  assign expBit = statByte[3'h7 - st.bitCnt];

  always_comb begin
    next_st = st;
    next_st.sckPrev = sckS;
    next_st.memWe = 1'b0;
    if (csS) begin
      if (st.clrPend) begin
        next_st.write_latch_flag = 1'b0;
      end
      // idle while deselected
      next_st.phase = PH_IDLE;
      next_st.clrPend = 1'b0;
      next_st.halted = 1'b0;
      next_st.hold = 1'b0;
      next_st.drive = 1'b0;
      next_st.bitCnt = 3'h0;
      next_st.addrLow = 1'b0;
    end else begin
      if (st.phase == PH_IDLE) begin
        next_st.phase = PH_OPCODE;
        next_st.mode3 = sckS;
      end
      // hold changes only with the clock low
      if (!sckS) begin
        next_st.hold = !holdS;
      end
      if (rise && !st.hold && st.phase != PH_IDLE) begin
        next_st.shiftIn = inByte[6:0];
        next_st.bitCnt = st.bitCnt + 3'h1;
        if (st.bitCnt == 3'h7) begin
          unique case (st.phase)
            PH_OPCODE: begin
              case (inByte)
                OP_SET_LATCH: begin
                  next_st.write_latch_flag = 1'b1;
                  next_st.phase = PH_DONE_IGN;
                end
                OP_CLEAR_LATCH: begin
                  next_st.clrPend = 1'b1;
                  next_st.phase = PH_DONE_IGN;
                end
                OP_READ_STATUS: begin
                  next_st.phase = PH_RDSTAT;
                end
                OP_WRITE_STATUS: begin
                  next_st.clrPend = 1'b1;
                  next_st.phase = PH_WRSTAT;
                end
                OP_READ_MEM: begin
                  next_st.isWrite = 1'b0;
                  next_st.phase = PH_ADDR;
                end
                OP_WRITE_MEM: begin
                  next_st.isWrite = 1'b1;
                  next_st.clrPend = 1'b1;
                  next_st.phase = PH_ADDR;
                end
                default: begin
                  next_st.phase = PH_DONE_IGN;
                end
              endcase
            end
            PH_ADDR: begin
              if (!st.addrLow) begin
                next_st.addr[14:8] = inByte[6:0];
                next_st.addrLow = 1'b1;
              end else begin
                next_st.addr[7:0] = inByte;
                next_st.phase = st.isWrite ? PH_WRDATA : PH_RDDATA;
              end
            end
            PH_WRDATA: begin
              if (!st.halted) begin
                // protect pin plays no part
                if (isProt(st.addr, st.bp)) begin
                  next_st.halted = 1'b1;
                end else begin
                  next_st.memWe = st.write_latch_flag;
                  next_st.memAddr = st.addr;
                  next_st.memData = inByte;
                  next_st.addr = st.addr + 15'h0001;
                end
              end
            end
            PH_RDDATA: begin
              next_st.addr = st.addr + 15'h0001;
            end
            PH_WRSTAT: begin
              // latch bit in the written byte is dropped
              if (st.write_latch_flag && !(st.pinEn && !wpS)) begin
                next_st.pinEn = inByte[SR_PIN_EN_BIT];
                next_st.bp = {inByte[SR_BP_HI_BIT], inByte[SR_BP_LO_BIT]};
              end
              next_st.phase = PH_DONE_IGN;
            end
            PH_IDLE, PH_RDSTAT, PH_DONE_IGN: begin
            end
          endcase
        end
      end
      if (fall && !st.hold && (st.phase == PH_RDDATA || st.phase == PH_RDSTAT)) begin
        next_st.drive = 1'b1;
        if (st.bitCnt == 3'h0) begin
          next_st.serOut = (st.phase == PH_RDSTAT) ? statByte[7] : rdData[7];
          next_st.shiftOut = (st.phase == PH_RDSTAT) ? {statByte[6:0], 1'b0}
                                                      : {rdData[6:0], 1'b0};
        end else begin
          next_st.serOut = st.shiftOut[7];
          next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
        end
      end
    end
    // output released while deselected or held
    next_st.serOutOe_b = !(next_st.drive && !next_st.hold);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign serOut = st.serOut;
  assign serOutOe_b = st.serOutOe_b;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  wel_set_a: assert property (opDone && inByte == OP_SET_LATCH |=> st.write_latch_flag)
    else $error("latch not set by set command");
  wel_only_a: assert property ($rose(st.write_latch_flag) |-> $past(opDone && inByte == OP_SET_LATCH))
    else $error("latch set without set command");
  wel_clear_a: assert property (csS && st.clrPend |=> !st.write_latch_flag)
    else $error("latch not cleared at select rise");
  arr_guard_a: assert property (st.memWe |-> st.write_latch_flag && !isProt(st.memAddr, st.bp))
    else $error("array write while disabled or protected");
  stat_guard_a: assert property ($changed({st.pinEn, st.bp})
      |-> $past(st.write_latch_flag) && !($past(st.pinEn) && !$past(wpS)))
    else $error("status changed while protected");
  stat_out_a: assert property (fall && !st.hold && !csS && st.phase == PH_RDSTAT
      |=> st.serOut == $past(expBit))
    else $error("status bit shifted out wrong");
  hold_pause_a: assert property (st.hold && !csS
      |=> csS || ($stable(st.bitCnt) && $stable(st.addr)))
    else $error("transfer advanced during hold");
  so_tri_a: assert property (csS |=> st.serOutOe_b)
    else $error("output driven while deselected");
  ign_tri_a: assert property (st.phase == PH_DONE_IGN |-> st.serOutOe_b)
    else $error("output driven after non-read command");
  wrap_a: assert property (rise && !st.hold && !csS && st.phase == PH_RDDATA
      && st.bitCnt == 3'h7 && st.addr == ADDR_MAX |=> st.addr == ADDR_ZERO)
    else $error("address did not wrap");
  halt_a: assert property (st.halted |-> !st.memWe ##1 !st.memWe)
    else $error("write after protected address reached");
  wr_byte_a: assert property (rise && !st.hold && !csS && st.phase == PH_WRDATA
      && st.bitCnt == 3'h7 && st.write_latch_flag && !st.halted && !isProt(st.addr, st.bp)
      |=> st.memWe && st.memData == $past(inByte))
    else $error("data byte not written at eighth bit");
  mode_a: assert property (st.phase == PH_IDLE && !csS |=> st.mode3 == $past(sckS))
    else $error("clock mode not captured at select fall");

  cov_set_write_latch_cmd_c: cover property (opDone && inByte == OP_SET_LATCH);
  cov_write_c: cover property (st.memWe);
  cov_stat_c: cover property ($changed(st.bp));
  cov_hold_c: cover property (st.hold && st.phase == PH_RDDATA && st.mode3);

endmodule

`default_nettype wire

// ---- rtl/sfp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module sfp_sync #(
  parameter int unsigned WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sfp_sync_t;

  sfp_sync_t st;
  sfp_sync_t next_st;

  if (WIDTH < 1) begin : gWidthCheck
    $error("sfp_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{s1: RESET_VAL, s2: RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;

endmodule

`default_nettype wire

// ---- tb/sfp_spi_master.sv ----
`timescale 1ns/10ps
`default_nettype none

module sfp_spi_master (
  // clock
  input  wire logic ref_clk,
  // serial pins
  output logic      chipSel_b,
  output logic      sckPin,
  output logic      siPin,
  input  wire logic serOut,
  input  wire logic serOutOe_b,
  // protection and hold pins
  output logic      writeProt_b,
  output logic      holdPin_b
);
  logic [7:0] txBuf[$];
  logic [7:0] rxBuf[$];
  int         holdByte;
  logic       mode3;

  initial begin
    chipSel_b   = 1'b1;
    sckPin      = 1'b0;
    siPin       = 1'b0;
    writeProt_b = 1'b1;
    holdPin_b   = 1'b1;
    holdByte    = -1;
    mode3       = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one framed transfer: txBuf out msb first, bytes seen on the output into rxBuf
  task automatic frame();
    logic [7:0] rx;
    rx = 8'h00;
    sckPin = mode3;
    tick(4);
    chipSel_b = 1'b0;
    rxBuf.delete();
    tick(4);
    foreach (txBuf[k]) begin
      for (int i = 7; i >= 0; i--) begin
        sckPin = 1'b0;
        siPin  = txBuf[k][i];
        tick(4);
        if (k == holdByte && i == 3) begin
          holdPin_b = 1'b0;
          tick(4);
          sckPin = 1'b1;
          siPin  = ~siPin;
          tick(4);
          sckPin = 1'b0;
          tick(4);
          holdPin_b = 1'b1;
          siPin     = txBuf[k][i];
          tick(4);
        end
        sckPin = 1'b1;
        tick(4);
        rx[i] = (serOutOe_b === 1'b0) ? serOut : 1'bx;
      end
      rxBuf.push_back(rx);
    end
    sckPin = mode3;
    siPin  = ~siPin;  // released line must not keep its last level
    tick(1);
    chipSel_b = 1'b1;
    tick(8);
  endtask
endmodule

`default_nettype wire

// ---- tb/test_sfp_protect_access.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_sfp_protect_access;
  import sfp_pkg::*;

  localparam int CYCLE_LIMIT = 40000;

  logic ref_clk = 1'b0;
  logic rst_b   = 1'b0;
  logic chipSel_b;
  logic sckPin;
  logic siPin;
  logic serOut;
  logic serOutOe_b;
  logic writeProt_b;
  logic holdPin_b;
  int   fails       = 0;
  int   checkCount  = 0;
  int   cycles      = 0;

  always #12.5 ref_clk = ~ref_clk;

  sfp_protect_access dut (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .chipSel_b   (chipSel_b),
    .sckPin      (sckPin),
    .siPin       (siPin),
    .serOut      (serOut),
    .serOutOe_b  (serOutOe_b),
    .writeProt_b (writeProt_b),
    .holdPin_b   (holdPin_b)
  );

  sfp_spi_master master (
    .ref_clk     (ref_clk),
    .chipSel_b   (chipSel_b),
    .sckPin      (sckPin),
    .siPin       (siPin),
    .serOut      (serOut),
    .serOutOe_b  (serOutOe_b),
    .writeProt_b (writeProt_b),
    .holdPin_b   (holdPin_b)
  );

  task automatic conclude();
    if (fails == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checkCount++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic send(input logic [7:0] op);
    master.txBuf = '{op};
    master.frame();
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
    master.txBuf = {OP_WRITE_MEM, a[15:8], a[7:0], d};
    master.frame();
  endtask

  // read burst; dummy ones on the input must not disturb the data
  task automatic rd(input logic [15:0] a, input logic [7:0] e[$]);
    master.txBuf = {OP_READ_MEM, a[15:8], a[7:0]};
    foreach (e[k]) master.txBuf.push_back(8'hFF);
    master.frame();
    foreach (e[k]) check(master.rxBuf[k + 3], e[k]);
  endtask

  task automatic st(input logic [7:0] e);
    master.txBuf = {OP_READ_STATUS, 8'h00};
    master.frame();
    check(master.rxBuf[1], e);
  endtask

  task automatic write_status_cmd(input logic [7:0] v);
    send(OP_SET_LATCH);
    master.txBuf = {OP_WRITE_STATUS, v};
    master.frame();
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      fails++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    st(8'h00);
    send(OP_SET_LATCH);
    st(8'h02);
    send(OP_CLEAR_LATCH);
    st(8'h00);
    send(OP_SET_LATCH);
    wr(16'hFFFE, '{8'h11, 8'h22, 8'h33});
    st(8'h00);
    send(OP_SET_LATCH);
    wr(16'h5FFF, '{8'h01, 8'h02, 8'h03});
    wr(16'h7FFE, '{8'h99});
    rd(16'h7FFE, '{8'h11, 8'h22, 8'h33});
    rd(16'h5FFF, '{8'h01, 8'h02, 8'h03});
    check({7'h00, serOutOe_b}, 8'h01);
    write_status_cmd(8'hFF);
    st(8'h8C);
    send(OP_SET_LATCH);
    wr(16'h0000, '{8'h55});
    rd(16'h0000, '{8'h33});
    master.writeProt_b = 1'b0;
    write_status_cmd(8'h00);
    st(8'h8C);
    master.writeProt_b = 1'b1;
    write_status_cmd(8'h84);
    st(8'h84);
    master.writeProt_b = 1'b0;
    send(OP_SET_LATCH);
    wr(16'h5FFF, '{8'hAA, 8'hBB, 8'hCC});
    rd(16'h5FFF, '{8'hAA, 8'h02, 8'h03});
    st(8'h84);
    master.writeProt_b = 1'b1;
    write_status_cmd(8'h08);
    st(8'h08);
    master.txBuf = {OP_WRITE_STATUS, 8'h8C};
    master.frame();
    st(8'h08);
    send(OP_SET_LATCH);
    master.holdByte = 3;
    wr(16'h3FFF, '{8'h44, 8'h66});
    rd(16'h3FFF, '{8'h44});
    master.holdByte = -1;
    master.txBuf = {8'hAB, OP_SET_LATCH, OP_READ_STATUS, 8'h00};
    master.frame();
    check(master.rxBuf[3], 8'hXX);
    st(8'h08);
    master.mode3 = 1'b1;
    send(OP_SET_LATCH);
    st(8'h0A);
    master.holdByte = 3;
    rd(16'h3FFF, '{8'h44});
    master.holdByte = -1;
    master.mode3 = 1'b0;
    send(OP_CLEAR_LATCH);
    st(8'h08);
    conclude();
  end
endmodule

`default_nettype wire
